/* src/ncs_pkg.sv */
// Contract
// - Program address is a 4-bit page above a 6-bit word, 1024 words total.
// - Each program page holds 64 words; the word counter spans one page.
// - Page register holds 0 to 15 and stays put during sequential execution.
// - Load-page-immediate stages a page; a taken jump or call moves it in.
// - Return restores page and word together in one step.
// - Word counter is 6-bit binary and increments on each instruction.
// - Reset clears word counter and page register to zero.
// - Jump, call, return load the word address instead of incrementing.
// - Return stack has two levels of word plus page.
// - Data memory is 32 nibbles; pointer bit 0 picks page, Y picks word.
// - Upper pointer bit moves Y=0 and Y=1 outputs from D0/D1 to DRIVE_OUT bits 8 and 9.
// - Y is memory word address, output selector, carrier mode and general.
// - 4-bit adder with accumulator; subtraction adds inverted accumulator plus one.
// - Status flag set on overflow, underflow or unequal compare; steers flow.
// - One-byte instructions, one completes every 48 clocks.
// - Jump, call and return keep the same one machine cycle timing.
// - Jump and call act only when the status flag is one.
package ncs_pkg;

  // Program address: page above word
  typedef struct packed {
    logic [3:0] page;
    logic [5:0] word;
  } ncs_paddr_s;

  // Data memory address: page bit above word
  typedef struct packed {
    logic       page;
    logic [3:0] word;
  } ncs_daddr_s;

  // Machine cycle timing in oscillator clocks
  localparam logic [5:0] CYCLE_CLOCKS = 6'h30;
  localparam logic [5:0] FETCH_AT     = 6'h18;
  localparam logic [5:0] EXEC_AT      = 6'h2f;

  // Reset values
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [5:0] WORD_RST = 6'h0;
  localparam logic       RUN_RST  = 1'b1;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_CORE  = 4'h4;
  localparam logic [3:0] OFS_STACK = 4'h8;

  // Instruction encodings
  localparam logic [1:0] GRP_MISC = 2'h0;
  localparam logic [1:0] GRP_IMM  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_CALL = 2'h3;
  localparam logic [1:0] IMM_LDPAGE = 2'h0;
  localparam logic [1:0] IMM_LDY  = 2'h1;
  localparam logic [1:0] IMM_ADD  = 2'h2;
  localparam logic [1:0] IMM_CMP  = 2'h3;
  localparam logic [7:0] OP_RET   = 8'h01;
  localparam logic [7:0] OP_LDAM  = 8'h02;
  localparam logic [7:0] OP_STMA  = 8'h03;
  localparam logic [7:0] OP_SUBM  = 8'h04;
  localparam logic [7:0] OP_SETO  = 8'h05;
  localparam logic [7:0] OP_CLRO  = 8'h06;
  localparam logic [7:0] OP_LDCM  = 8'h07;
  localparam logic [7:0] OP_LDAY  = 8'h0c;
  localparam logic [7:0] OP_LDYA  = 8'h0d;
  localparam logic [5:0] OP_LDX   = 6'h02;

endpackage

/* src/ncs_sequencer.sv */
`timescale 1ns/100ps
module ncs_sequencer (
  input  wire logic               CORE_CLK,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire logic [3:0]         ADDRESS,
  input  wire logic               READ,
  input  wire logic               WRITE,
  input  wire logic [31:0]        WRITEDATA,
  output logic      [31:0]        READDATA,
  output logic                    WAITREQUEST,
  output ncs_pkg::ncs_paddr_s     PROG_ADDR,
  input  wire logic [7:0]         PROG_DATA,
  output ncs_pkg::ncs_daddr_s     DMEM_ADDR,
  output logic      [3:0]         DMEM_WDATA,
  output logic                    DMEM_WE,
  input  wire logic [3:0]         DMEM_RDATA,
  output logic      [9:0]         DRIVE_OUT,
  output logic      [2:0]         CARRIER_MODE,
  output logic                    INSTR_DONE
);
  import ncs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [5:0]  machine_cycle_counter;
  logic [5:0]  word_counter;
  logic [3:0]  page_select_reg;
  logic [3:0]  page_staging_reg;
  ncs_paddr_s  return_stack [2];
  logic [7:0]  instr;
  logic        status_flag;
  logic [3:0]  acc;
  logic [3:0]  y_reg;
  logic        ram_page_bit;
  logic        output_bank_select_bit;
  logic        run;

  ////////////////////////////////////////////////////////////////////////
  // Machine cycle: fetch at the start of the second half, execute at the last clock
  wire tick   = CE && run;
  wire fetch  = tick && (machine_cycle_counter == FETCH_AT);
  wire exec   = tick && (machine_cycle_counter == EXEC_AT);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      machine_cycle_counter <= 6'h00;
    end else if (tick) begin
      machine_cycle_counter <= exec ? 6'h00 : machine_cycle_counter + 6'h01;
    end
  end

  // Capture the instruction byte from program memory
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      instr <= 8'h00;
    end else if (fetch) begin
      instr <= PROG_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire [1:0] grp      = instr[7:6];
  wire [1:0] imm_sel  = instr[5:4];
  wire [3:0] imm      = instr[3:0];
  wire [5:0] target   = instr[5:0];
  wire       is_jump  = (grp == GRP_JUMP);
  wire       is_call  = (grp == GRP_CALL);
  wire       is_ret   = (instr == OP_RET);
  wire       is_imm   = (grp == GRP_IMM);
  wire       is_ldpage = is_imm && (imm_sel == IMM_LDPAGE);
  wire       is_ldy   = is_imm && (imm_sel == IMM_LDY);
  wire       is_add   = is_imm && (imm_sel == IMM_ADD);
  wire       is_cmp   = is_imm && (imm_sel == IMM_CMP);
  wire       is_ldx   = (instr[7:2] == OP_LDX);
  wire       is_out   = (instr == OP_SETO) || (instr == OP_CLRO);
  wire       jump_go  = is_jump && status_flag;
  wire       call_go  = is_call && status_flag;
  wire       redirect = jump_go || call_go || is_ret;

  ////////////////////////////////////////////////////////////////////////
  // Adder/comparator
  wire [4:0] add_sum  = {1'b0, acc} + {1'b0, imm};
  wire [4:0] sub_sum  = {1'b0, DMEM_RDATA} + {1'b0, ~acc} + 5'h01;
  wire       unequal  = (acc != imm);

  // Flag: designated instructions report their event, all others set it
  logic next_flag;
  always_comb begin
    next_flag = 1'b1;
    if (is_add) begin
      next_flag = add_sum[4];
    end else if (instr == OP_SUBM) begin
      next_flag = ~sub_sum[4];
    end else if (is_cmp) begin
      next_flag = unequal;
    end
  end

  // Accumulator source
  logic [3:0] next_acc;
  always_comb begin
    next_acc = acc;
    if (is_add) begin
      next_acc = add_sum[3:0];
    end else if (instr == OP_SUBM) begin
      next_acc = sub_sum[3:0];
    end else if (instr == OP_LDAM) begin
      next_acc = DMEM_RDATA;
    end else if (instr == OP_LDAY) begin
      next_acc = y_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program address sequencing
  wire [5:0] next_word = is_ret  ? return_stack[0].word :
                         redirect ? target :
                         word_counter + 6'h01;
  wire [3:0] next_page = is_ret  ? return_stack[0].page :
                         redirect ? page_staging_reg :
                         page_select_reg;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      word_counter    <= WORD_RST;
      page_select_reg <= PAGE_RST;
    end else if (exec) begin
      word_counter    <= next_word;
      page_select_reg <= next_page;
    end
  end

  // Page staging written by load-page-immediate
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      page_staging_reg <= PAGE_RST;
    end else if (exec && is_ldpage) begin
      page_staging_reg <= imm;
    end
  end

  // Two-level return stack
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      return_stack[0] <= '0;
      return_stack[1] <= '0;
    end else if (exec && call_go) begin
      return_stack[0] <= '{page: page_select_reg, word: word_counter + 6'h01};
      return_stack[1] <= return_stack[0];
    end else if (exec && is_ret) begin
      return_stack[0] <= return_stack[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data path registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      status_flag            <= 1'b1;
      acc                    <= 4'h0;
      y_reg                  <= 4'h0;
      ram_page_bit           <= 1'b0;
      output_bank_select_bit <= 1'b0;
    end else if (exec) begin
      status_flag <= next_flag;
      acc         <= next_acc;
      if (is_ldy) begin
        y_reg <= imm;
      end else if (instr == OP_LDYA) begin
        y_reg <= acc;
      end
      if (is_ldx) begin
        ram_page_bit           <= instr[0];
        output_bank_select_bit <= instr[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output line selection from the pointer pair
  wire       out_val  = (instr == OP_SETO);
  wire       y_low    = (y_reg[3:1] == 3'h0);
  wire [3:0] out_idx  = (output_bank_select_bit && y_low) ? {3'h4, y_reg[0]}
                        : y_reg;
  wire       out_hit  = exec && is_out && (out_idx <= 4'h9) &&
                        (output_bank_select_bit ? y_low : !y_reg[3] || !y_low);

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_drive
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          DRIVE_OUT[gi] <= 1'b0;
        end else if (out_hit && (out_idx == 4'(gi))) begin
          DRIVE_OUT[gi] <= out_val;
        end
      end
    end
  endgenerate

  // Carrier mode taken from the pointer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CARRIER_MODE <= 3'h0;
    end else if (exec && (instr == OP_LDCM)) begin
      CARRIER_MODE <= y_reg[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory ports
  wire ncs_paddr_s next_paddr = '{page: page_select_reg, word: word_counter};

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PROG_ADDR  <= '0;
      DMEM_ADDR  <= '0;
      DMEM_WDATA <= 4'h0;
      DMEM_WE    <= 1'b0;
      INSTR_DONE <= 1'b0;
    end else if (CE) begin
      PROG_ADDR  <= next_paddr;
      DMEM_ADDR  <= '{page: ram_page_bit, word: y_reg};
      DMEM_WDATA <= acc;
      DMEM_WE    <= exec && (instr == OP_STMA);
      INSTR_DONE <= exec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  wire        req     = READ || WRITE;
  wire        hit_ctl = (ADDRESS == OFS_CTRL);
  wire [31:0] core_word = {7'h00, status_flag, acc, y_reg,
                           output_bank_select_bit, ram_page_bit,
                           page_staging_reg, page_select_reg, word_counter};
  wire [31:0] stack_word = {12'h000, return_stack[1], return_stack[0]};
  logic [31:0] next_rdata;
  always_comb begin
    if (hit_ctl) begin
      next_rdata = {31'h0, run};
    end else if (ADDRESS == OFS_CORE) begin
      next_rdata = core_word;
    end else if (ADDRESS == OFS_STACK) begin
      next_rdata = stack_word;
    end else begin
      next_rdata = 32'h0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= 32'h0;
      run         <= RUN_RST;
    end else if (CE) begin
      WAITREQUEST <= !(req && WAITREQUEST);
      if (READ && WAITREQUEST) begin
        READDATA <= next_rdata;
      end
      if (WRITE && !WAITREQUEST && hit_ctl) begin
        run <= WRITEDATA[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_call_taken;
    exec && call_go;
  endsequence

  sequence s_return_exec;
    exec && is_ret;
  endsequence

  a_word_step: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && !redirect |=> word_counter == $past(word_counter) + 6'h01)
    else $error("word counter did not step");

  a_page_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && !redirect |=> $stable(page_select_reg))
    else $error("page changed without redirect");

  a_jump_target: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && jump_go |=> word_counter == $past(instr[5:0]) &&
                        page_select_reg == $past(page_staging_reg))
    else $error("jump target wrong");

  a_jump_skip: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && is_jump && !status_flag |=> word_counter == $past(word_counter) + 6'h01)
    else $error("untaken jump redirected");

  a_call_return: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_call_taken ##1 (!exec && !RST)[*1] |->
      return_stack[0].word == $past(word_counter, 2) + 6'h01 &&
      return_stack[0].page == $past(page_select_reg, 2))
    else $error("call pushed wrong return");

  a_return_pop: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_return_exec |=> word_counter == $past(return_stack[0].word) &&
                      page_select_reg == $past(return_stack[0].page) &&
                      return_stack[0] == $past(return_stack[1]))
    else $error("return pop wrong");

  a_exec_spacing: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec |=> !exec[*8])
    else $error("instructions closer than a machine cycle");

  a_cmp_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && is_cmp |=> status_flag == ($past(acc) != $past(imm)))
    else $error("compare flag wrong");

  a_sub_result: assert property (@(posedge CORE_CLK) disable iff (RST)
    exec && (instr == OP_SUBM) |=> acc == $past(DMEM_RDATA) - $past(acc))
    else $error("subtract result wrong");

  a_bus_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
    req && WAITREQUEST && CE |=> !WAITREQUEST)
    else $error("bus not answered");

endmodule

/* tb/ncs_mem_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Program and data memory arrays seen by the sequencer
module ncs_mem_model (
  input  wire logic           clk,
  input  ncs_pkg::ncs_paddr_s prog_addr,
  output logic [7:0]          prog_data,
  input  ncs_pkg::ncs_daddr_s dmem_addr,
  input  wire logic [3:0]     dmem_wdata,
  input  wire logic           dmem_we,
  output logic [3:0]          dmem_rdata
);
  import ncs_pkg::*;
  logic [7:0] rom [0:1023];
  logic [3:0] ram [0:31];
  // Program byte addressed by page above word
  assign prog_data = rom[prog_addr];
  // Data nibble addressed by page bit above word pointer
  assign dmem_rdata = ram[dmem_addr];
  // Store on the write pulse
  always @(posedge clk) begin
    if (dmem_we === 1'b1) begin
      ram[dmem_addr] <= dmem_wdata;
    end
  end
endmodule

/* tb/nibble_cpu_program_sequencer_tb.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module nibble_cpu_program_sequencer_tb;
  import ncs_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic [3:0]  ADDRESS = 4'h0;
  logic        READ = 1'b0;
  logic        WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic        WAITREQUEST;
  ncs_paddr_s  PROG_ADDR;
  logic [7:0]  PROG_DATA;
  ncs_daddr_s  DMEM_ADDR;
  logic [3:0]  DMEM_WDATA;
  logic        DMEM_WE;
  logic [3:0]  DMEM_RDATA;
  logic [9:0]  DRIVE_OUT;
  logic [2:0]  CARRIER_MODE;
  logic        INSTR_DONE;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          last = 0;
  logic [31:0] rd;
  logic [7:0]  p0 [0:17] = '{8'h45, 8'h73, 8'hca, 8'h70, 8'h80, 8'h6f, 8'h61, 8'h53, 8'h09,
                             8'h0c, 8'h03, 8'h0a, 8'h51, 8'h05, 8'h04, 8'h00, 8'h40, 8'hbe};
  logic [9:0]  exp_pa [0:23] = '{10'h001, 10'h002, 10'h14a, 10'h14b, 10'h080, 10'h14c,
                                 10'h003, 10'h004, 10'h005, 10'h006, 10'h007, 10'h008,
                                 10'h009, 10'h00a, 10'h00b, 10'h00c, 10'h00d, 10'h00e,
                                 10'h00f, 10'h010, 10'h011, 10'h03e, 10'h03f, 10'h000};

  // Clock and cycle count
  always #10 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= cyc + 1;

  ncs_sequencer uut (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
    .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA), .DMEM_WE(DMEM_WE),
    .DMEM_RDATA(DMEM_RDATA), .DRIVE_OUT(DRIVE_OUT), .CARRIER_MODE(CARRIER_MODE),
    .INSTR_DONE(INSTR_DONE));
  ncs_mem_model mem (.clk(CORE_CLK), .prog_addr(PROG_ADDR), .prog_data(PROG_DATA),
    .dmem_addr(DMEM_ADDR), .dmem_wdata(DMEM_WDATA), .dmem_we(DMEM_WE),
    .dmem_rdata(DMEM_RDATA));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Value comparison
  task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Avalon transfer: hold the request until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    ADDRESS <= a;
    WRITEDATA <= wd;
    READ <= ~wr;
    WRITE <= wr;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    d = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask

  // Wait for one executed instruction, bounded
  task wait_done;
    int n;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (INSTR_DONE !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset state and unmapped read
  task t_reset;
    cmp("prog_addr", 32'h0, PROG_ADDR);
    bus(1'b0, OFS_CTRL, 32'h0, rd);
    cmp("ctrl run", 32'h1, rd[0]);
    bus(1'b0, OFS_CORE, 32'h0, rd);
    cmp("core word page staging", 32'h0, rd[13:0]);
    cmp("core flag", 32'h1, rd[24]);
    bus(1'b0, 4'hc, 32'h0, rd);
    cmp("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask

  // Program walk through pages, stack, flag and data paths
  task t_program;
    for (int k = 0; k < 24; k++) begin
      wait_done();
      if (k > 0) cmp("cycle length", 32'd48, cyc - last);
      last = cyc;
      @(posedge CORE_CLK);
      cmp("prog_addr", exp_pa[k], PROG_ADDR);
      if (k == 1) begin
        bus(1'b0, OFS_CORE, 32'h0, rd);
        cmp("staged page", 32'h5, rd[13:10]);
        cmp("page held", 32'h0, rd[9:6]);
        cmp("flag unequal", 32'h1, rd[24]);
      end
      if (k == 4) begin
        bus(1'b0, OFS_STACK, 32'h0, rd);
        cmp("stack", {4'h0, 6'h03, 4'h5, 6'h0c}, rd[19:0]);
      end
      if (k == 10) begin
        bus(1'b0, OFS_CORE, 32'h0, rd);
        cmp("acc wrap", 32'h0, rd[23:20]);
        cmp("flag carry", 32'h1, rd[24]);
      end
      if (k == 14) cmp("ram store", 32'h3, mem.ram[5'h13]);
      if (k == 17) cmp("drive out", 32'h200, DRIVE_OUT);
      if (k == 22) cmp("carrier mode", 32'h1, CARRIER_MODE);
      if (k == 23) cmp("drive cleared", 32'h0, DRIVE_OUT);
      if (k == 18) begin
        bus(1'b0, OFS_CORE, 32'h0, rd);
        cmp("acc sub", 32'h4, rd[23:20]);
        cmp("flag no borrow", 32'h0, rd[24]);
      end
    end
    $display("test program done");
  endtask

  // Stopped sequencing freezes the address and completions
  task t_stop;
    logic [9:0] held;
    bus(1'b1, OFS_CTRL, 32'h0, rd);
    @(posedge CORE_CLK);
    @(posedge CORE_CLK);
    held = PROG_ADDR;
    for (int i = 0; i < 100; i++) begin
      @(posedge CORE_CLK);
      if (INSTR_DONE !== 1'b0) cmp("done while stopped", 32'h0, INSTR_DONE);
    end
    cmp("held address", held, PROG_ADDR);
    $display("test stop done");
  endtask

  // Mid-run reset, then a clock-enable pause before the first completion
  task t_restart;
    int rel;
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    rel = cyc;
    cmp("prog_addr after reset", 32'h0, PROG_ADDR);
    bus(1'b0, OFS_STACK, 32'h0, rd);
    cmp("stack after reset", 32'h0, rd);
    bus(1'b0, OFS_CTRL, 32'h0, rd);
    cmp("run after reset", 32'h1, rd[0]);
    CE <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    CE <= 1'b1;
    wait_done();
    cmp("first completion", 32'd59, cyc - rel);
    @(posedge CORE_CLK);
    cmp("prog_addr restart", 32'h001, PROG_ADDR);
    $display("test restart done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Load memories, reset, run scenarios
  initial begin
    for (int i = 0; i < 1024; i++) mem.rom[i] = 8'h00;
    for (int i = 0; i < 32; i++) mem.ram[i] = 4'h0;
    for (int i = 0; i < 18; i++) mem.rom[i] = p0[i];
    mem.rom[330] = 8'h42;
    mem.rom[331] = 8'hc0;
    mem.rom[332] = 8'h01;
    mem.rom[128] = 8'h01;
    mem.rom[62] = 8'h07;
    mem.rom[63] = 8'h06;
    mem.ram[5'h01] = 4'h7;
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_reset();
    t_program();
    t_stop();
    t_restart();
    close_out();
  end
endmodule
